// ==== hdl/led_sink_pkg.sv ====
// Purpose: shared constants and carriers of the LED sink shift/diag logic
// Assumes: 20 MHz system clock, 24-bit serial words
// Notes: what this block does:
// What this block does
// - sixteen outputs form eight independent pairs
// - diag bit turns odd pin into sense
// - sense pin always high-Z, sensed only while paired output on
// - sustained high sense sets open fault
// - open fault keeps output, latched until read
// - sustained low sense sets short fault
// - short fault keeps output, latched until read
// - overtemp disables outputs, flag until read
// - diag plus odd bit flags conflict
// - conflict clears after fix then read
// - fault flag low while any flag set
// - shift on shift clock, store on latch
// - storage drives outputs only when enabled
// - diag byte first, then sixteen output bits
// - latch loads faults, MSB on serial out
// - one fault bit per shift falling edge
// - six-bit CRC remainder, polynomial 0x43
// - CRC leaves configuration values untouched
// - clear input resets every register except the input synchronisers
// - high gate forces governed outputs off
// - gate one outputs 0-7, gate two 8-15
// - deglitch interval is 35 microseconds
// - enable high resets and holds standby
package led_sink_pkg;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned PAIRS = 8;
    localparam int unsigned CHANNELS = 16;
    localparam int unsigned CRC_W = 6;
    localparam logic [6:0] CRC_POLY = 7'h43;
    localparam logic [WORD_W-1:0] SETUP_RESET = 24'h00_0000;
    localparam int unsigned DIAG_LSB = 16;
    localparam int unsigned GATE1_LAST = 7;
    localparam logic [4:0] RB_LAST_IDX = 5'h17;
    localparam logic [4:0] RB_DONE_IDX = 5'h18;
    localparam int unsigned CLOCK_MHZ = 20;
    localparam int unsigned OPEN_DEGLITCH_NS = 35000;
    localparam int unsigned SHORT_DEGLITCH_NS = 35000;
    localparam int unsigned DEG_W = 10;
    localparam int unsigned OPEN_DEG_CYC =
        (OPEN_DEGLITCH_NS * CLOCK_MHZ) / 1000;
    localparam int unsigned SHORT_DEG_CYC =
        (SHORT_DEGLITCH_NS * CLOCK_MHZ) / 1000;

    typedef struct packed {
        logic [PAIRS-1:0] diag;
        logic [CHANNELS-1:0] drain;
    } setup_word_t;

    typedef struct packed {
        logic [2*PAIRS-1:0] pair_bits;
        logic overtemp;
        logic conflict;
        logic [CRC_W-1:0] crc;
    } fault_word_t;
endpackage

// ==== hdl/led_sink_shift_diag_logic.sv ====
// Purpose: control, diagnostics and serial interface of a 16-channel sink
// Assumes: comparator results arrive as logic levels from analog front end
// Notes: shift/latch edges form the link domain, the rest runs on clock
`timescale 1ns/1ps
`default_nettype none
module led_sink_shift_diag_logic (
    // System
    input wire logic clock,
    input wire logic sys_rst,
    // Device pins
    input wire logic clear_n,
    input wire logic enable,
    input wire logic group_gate_1,
    input wire logic group_gate_2,
    // Serial link
    input wire logic shift_clock,
    input wire logic latch_clock,
    input wire logic serial_in,
    output logic serial_out,
    // Analog front end
    input wire logic [led_sink_pkg::PAIRS-1:0] open_cmp,
    input wire logic [led_sink_pkg::PAIRS-1:0] short_cmp,
    input wire logic overtemp_in,
    // Open-drain outputs
    output logic [led_sink_pkg::CHANNELS-1:0] low_side_out_o,
    output logic [led_sink_pkg::CHANNELS-1:0] low_side_out_oe_n,
    output logic fault_flag_out_o,
    output logic fault_flag_out_oe_n
);
    localparam int unsigned NS = 2 * led_sink_pkg::PAIRS + 7;

    function automatic logic [led_sink_pkg::CRC_W-1:0] crc6(
        input logic [led_sink_pkg::WORD_W-1:0] d);
        logic [led_sink_pkg::CRC_W-1:0] rem;
        logic fb;
        rem = '0;
        for (int i = led_sink_pkg::WORD_W - 1; i >= 0; i--) begin
            fb = rem[led_sink_pkg::CRC_W-1] ^ d[i];
            rem = {rem[led_sink_pkg::CRC_W-2:0], 1'b0};
            if (fb) begin
                rem = rem ^ led_sink_pkg::CRC_POLY[led_sink_pkg::CRC_W-1:0];
            end
        end
        return rem;
    endfunction

    // Link domain: pins reset it directly since it has no free clock
    logic link_rst;
    logic [led_sink_pkg::WORD_W-1:0] shift_in_r;
    led_sink_pkg::setup_word_t store_r;
    led_sink_pkg::fault_word_t snap_r;
    led_sink_pkg::fault_word_t fault_word_r;
    logic latch_tog_r;
    logic rb_seen_r;
    logic read_tog_r;
    logic [4:0] rb_idx_r;
    logic [4:0] rb_sel;

    assign link_rst = ~clear_n | enable;

    always_ff @(posedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            shift_in_r <= led_sink_pkg::SETUP_RESET;
        end else begin
            shift_in_r <= {shift_in_r[led_sink_pkg::WORD_W-2:0], serial_in};
        end
    end

    // latch stores word, snapshots faults and CRC
    // Fault word is sampled raw; flags are sticky so tearing is rare
    always_ff @(posedge latch_clock or posedge link_rst) begin
        if (link_rst) begin
            store_r <= led_sink_pkg::SETUP_RESET;
            snap_r <= '0;
            latch_tog_r <= 1'b0;
        end else begin
            store_r <= shift_in_r;
            snap_r <= {fault_word_r[led_sink_pkg::WORD_W-1:
                led_sink_pkg::CRC_W], crc6(shift_in_r)};
            latch_tog_r <= ~latch_tog_r;
        end
    end

    // readback index, relies on the latch-to-shift spacing
    always_ff @(negedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            rb_seen_r <= 1'b0;
            rb_idx_r <= 5'h00;
            read_tog_r <= 1'b0;
        end else if (latch_tog_r != rb_seen_r) begin
            rb_seen_r <= latch_tog_r;
            rb_idx_r <= 5'h01;
        end else if (rb_idx_r != led_sink_pkg::RB_DONE_IDX) begin
            rb_idx_r <= rb_idx_r + 5'h01;
            if (rb_idx_r + 5'h01 == led_sink_pkg::RB_LAST_IDX) begin
                read_tog_r <= ~read_tog_r;
            end
        end
    end

    // MSB shows right after the latch edge
    assign rb_sel = led_sink_pkg::RB_LAST_IDX - rb_idx_r;
    always_comb begin
        if (latch_tog_r != rb_seen_r) begin
            serial_out = snap_r[led_sink_pkg::WORD_W-1];
        end else if (rb_idx_r == led_sink_pkg::RB_DONE_IDX) begin
            serial_out = 1'b0;
        end else begin
            serial_out = snap_r[rb_sel];
        end
    end

    // Clock domain: two-flop synchronisers for every foreign input
    logic [NS-1:0] async_in;
    logic [NS-1:0] meta_r;
    logic [NS-1:0] sync_r;
    logic clear_n_s, enable_s, gate1_s, gate2_s, ot_s;
    logic latch_tog_s, read_tog_s;
    logic [led_sink_pkg::PAIRS-1:0] open_s, short_s;

    assign async_in = {clear_n, enable, group_gate_1, group_gate_2,
        overtemp_in, latch_tog_r, read_tog_r, open_cmp, short_cmp};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign {clear_n_s, enable_s, gate1_s, gate2_s, ot_s, latch_tog_s,
        read_tog_s, open_s, short_s} = sync_r;

    logic rst_all;
    logic latch_seen_r, read_seen_r;
    logic latch_evt, read_evt;
    led_sink_pkg::setup_word_t cfg_r;
    logic ot_flag_r, conflict_flag_r;
    logic [led_sink_pkg::PAIRS-1:0] open_flag_r, short_flag_r;
    logic [led_sink_pkg::PAIRS-1:0] diag_eff, conflict, mon;
    logic [led_sink_pkg::PAIRS-1:0] open_cond, short_cond;
    logic [led_sink_pkg::CHANNELS-1:0] gate_on;
    logic any_flag;

    assign rst_all = sys_rst | ~clear_n_s | enable_s;
    assign latch_evt = latch_tog_s ^ latch_seen_r;
    assign read_evt = read_tog_s ^ read_seen_r;

    always_ff @(posedge clock) begin
        if (rst_all) begin
            latch_seen_r <= 1'b0;
            read_seen_r <= 1'b0;
        end else begin
            latch_seen_r <= latch_tog_s;
            read_seen_r <= read_tog_s;
        end
    end

    // storage word taken once its latch toggle has settled
    always_ff @(posedge clock) begin
        if (rst_all) begin
            cfg_r <= led_sink_pkg::SETUP_RESET;
        end else if (latch_evt) begin
            cfg_r <= store_r;
        end
    end

    genvar p;
    generate
        for (p = 0; p < led_sink_pkg::PAIRS; p++) begin : g_pair
            logic [led_sink_pkg::DEG_W-1:0] open_cnt_r, short_cnt_r;

            if (2 * p <= led_sink_pkg::GATE1_LAST) begin : g_g1
                assign gate_on[2*p] = cfg_r.drain[2*p] & ~gate1_s & ~ot_flag_r;
                assign gate_on[2*p+1] =
                    cfg_r.drain[2*p+1] & ~gate1_s & ~ot_flag_r;
            end else begin : g_g2
                assign gate_on[2*p] = cfg_r.drain[2*p] & ~gate2_s & ~ot_flag_r;
                assign gate_on[2*p+1] =
                    cfg_r.drain[2*p+1] & ~gate2_s & ~ot_flag_r;
            end

            // odd bit wins over diag bit
            assign conflict[p] = cfg_r.diag[p] & cfg_r.drain[2*p+1];
            assign diag_eff[p] = cfg_r.diag[p] & ~cfg_r.drain[2*p+1];
            // sense only while the even output conducts
            assign mon[p] = diag_eff[p] & gate_on[2*p];
            assign open_cond[p] = mon[p] & open_s[p];
            assign short_cond[p] = mon[p] & short_s[p];

            always_ff @(posedge clock) begin
                if (rst_all) begin
                    low_side_out_oe_n[2*p] <= 1'b1;
                    low_side_out_oe_n[2*p+1] <= 1'b1;
                end else begin
                    low_side_out_oe_n[2*p] <= ~gate_on[2*p];
                    low_side_out_oe_n[2*p+1] <= ~gate_on[2*p+1] | diag_eff[p];
                end
            end

            // deglitch counters restart on any gap
            always_ff @(posedge clock) begin
                if (rst_all || !open_cond[p]) begin
                    open_cnt_r <= '0;
                end else if (open_cnt_r !=
                    led_sink_pkg::DEG_W'(led_sink_pkg::OPEN_DEG_CYC)) begin
                    open_cnt_r <= open_cnt_r + 1'b1;
                end
            end

            always_ff @(posedge clock) begin
                if (rst_all || !short_cond[p]) begin
                    short_cnt_r <= '0;
                end else if (short_cnt_r !=
                    led_sink_pkg::DEG_W'(led_sink_pkg::SHORT_DEG_CYC)) begin
                    short_cnt_r <= short_cnt_r + 1'b1;
                end
            end

            // set wins; clear needs read with condition gone
            always_ff @(posedge clock) begin
                if (rst_all) begin
                    open_flag_r[p] <= 1'b0;
                end else if (open_cnt_r ==
                    led_sink_pkg::DEG_W'(led_sink_pkg::OPEN_DEG_CYC - 1)) begin
                    open_flag_r[p] <= 1'b1;
                end else if (read_evt && !open_cond[p]) begin
                    open_flag_r[p] <= 1'b0;
                end
            end

            always_ff @(posedge clock) begin
                if (rst_all) begin
                    short_flag_r[p] <= 1'b0;
                end else if (short_cnt_r ==
                    led_sink_pkg::DEG_W'(led_sink_pkg::SHORT_DEG_CYC - 1)) begin
                    short_flag_r[p] <= 1'b1;
                end else if (read_evt && !short_cond[p]) begin
                    short_flag_r[p] <= 1'b0;
                end
            end

            assign low_side_out_o[2*p] = 1'b0;
            assign low_side_out_o[2*p+1] = 1'b0;
        end
    endgenerate

    // overtemp flag, set wins over read clear
    always_ff @(posedge clock) begin
        if (rst_all) begin
            ot_flag_r <= 1'b0;
        end else if (ot_s) begin
            ot_flag_r <= 1'b1;
        end else if (read_evt) begin
            ot_flag_r <= 1'b0;
        end
    end

    // conflict clears only on read after a clean setup
    always_ff @(posedge clock) begin
        if (rst_all) begin
            conflict_flag_r <= 1'b0;
        end else if (|conflict) begin
            conflict_flag_r <= 1'b1;
        end else if (read_evt) begin
            conflict_flag_r <= 1'b0;
        end
    end

    assign any_flag = (|open_flag_r) | (|short_flag_r) | ot_flag_r |
        conflict_flag_r;
    assign fault_flag_out_o = 1'b0;

    always_ff @(posedge clock) begin
        if (rst_all) begin
            fault_flag_out_oe_n <= 1'b1;
        end else begin
            fault_flag_out_oe_n <= ~any_flag;
        end
    end

    // readback layout, CRC slot filled at the latch edge
    always_ff @(posedge clock) begin
        if (rst_all) begin
            fault_word_r <= '0;
        end else begin
            for (int i = 0; i < led_sink_pkg::PAIRS; i++) begin
                fault_word_r.pair_bits[2*i+1] <= open_flag_r[i];
                fault_word_r.pair_bits[2*i] <= short_flag_r[i];
            end
            fault_word_r.overtemp <= ot_flag_r;
            fault_word_r.conflict <= conflict_flag_r;
            fault_word_r.crc <= '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst_all);

    // Pair 2 is the pair the fault scenarios exercise
    sequence s_open_ripe;
        open_cond[2] && g_pair[2].open_cnt_r ==
            led_sink_pkg::DEG_W'(led_sink_pkg::OPEN_DEG_CYC - 1);
    endsequence
    sequence s_open_gone_read;
        read_evt && !open_cond[2] && g_pair[2].open_cnt_r !=
            led_sink_pkg::DEG_W'(led_sink_pkg::OPEN_DEG_CYC - 1);
    endsequence
    sequence s_short_ripe;
        short_cond[2] && g_pair[2].short_cnt_r ==
            led_sink_pkg::DEG_W'(led_sink_pkg::SHORT_DEG_CYC - 1);
    endsequence

    AST_OPEN_SET: assert property (s_open_ripe |=> open_flag_r[2])
        else $error("open fault not latched after deglitch");
    AST_OPEN_HOLD: assert property (
        open_flag_r[2] && !read_evt |=> open_flag_r[2])
        else $error("open fault dropped without a read");
    AST_OPEN_CLR: assert property (
        open_flag_r[2] ##0 s_open_gone_read |=> !open_flag_r[2])
        else $error("open fault not cleared by read");
    AST_OPEN_DRIVE: assert property (
        open_flag_r[2] && gate_on[4] |=> !low_side_out_oe_n[4])
        else $error("open fault switched the output off");
    AST_SHORT_SET: assert property (s_short_ripe |=> short_flag_r[2])
        else $error("short fault not latched after deglitch");
    AST_SHORT_EARLY: assert property (
        short_cond[2] && $rose(short_cond[2]) |-> ##1 !$rose(short_flag_r[2])
        [*8])
        else $error("short fault set before deglitch");
    AST_SHORT_HOLD: assert property (
        short_flag_r[2] && !read_evt |=> short_flag_r[2])
        else $error("short fault dropped without a read");
    AST_OT_OFF: assert property (ot_flag_r |=> &low_side_out_oe_n)
        else $error("output active during overtemp");
    AST_OT_CLR: assert property (
        ot_flag_r && read_evt && !ot_s |=> !ot_flag_r)
        else $error("overtemp flag not cleared by read");
    AST_CONFLICT: assert property (
        conflict[2] && gate_on[5] |=> conflict_flag_r &&
        !low_side_out_oe_n[5])
        else $error("conflict not flagged or odd pin not driven");
    AST_CONF_KEEP: assert property (
        conflict_flag_r && |conflict |=> conflict_flag_r)
        else $error("conflict cleared while still present");
    AST_CONF_CLR: assert property (
        conflict_flag_r && !(|conflict) && read_evt |=> !conflict_flag_r)
        else $error("conflict flag not cleared by read");
    AST_FLAG_PIN: assert property (any_flag |=> !fault_flag_out_oe_n)
        else $error("fault pin not low with flag set");
    AST_FLAG_FREE: assert property (!any_flag |=> fault_flag_out_oe_n)
        else $error("fault pin held low with no flag");
    AST_GATE_OFF: assert property (gate1_s |=> &low_side_out_oe_n[7:0])
        else $error("gate high but low half driving");
    AST_GATE2_OFF: assert property (
        gate2_s |=> &low_side_out_oe_n[15:8])
        else $error("gate high but upper half driving");
    AST_SENSE_HIZ: assert property (
        diag_eff[2] |=> low_side_out_oe_n[5])
        else $error("sense pin driven");
    AST_SHORT_KEEP: assert property (
        short_flag_r[2] && gate_on[4] |=> !low_side_out_oe_n[4])
        else $error("short fault switched the output off");
    AST_CFG_LOAD: assert property (
        latch_evt |=> cfg_r == $past(store_r))
        else $error("latched word not taken into configuration");
endmodule
`default_nettype wire

// ==== tb/host_link_model.sv ====
// Purpose: host side of the serial shift link, word write with readback
// Assumes: link clock of 15 ns period, idle low between frames
// Notes: readback of the previous latch is sampled while a new word shifts
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // Link pins
    output logic shift_clock,
    output logic latch_clock,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        shift_clock = 1'b0;
        latch_clock = 1'b0;
        serial_in = 1'b1;
    end

    task automatic frame(input logic [23:0] w, output logic [23:0] r);
        #3.3;
        for (int i = 23; i >= 0; i--) begin
            serial_in = w[i];
            #7.5 shift_clock = 1'b1;
            #3.0 r[i] = serial_out;
            #4.5 shift_clock = 1'b0;
        end
        // Released line shows the inverse, not a stale bit
        serial_in = ~w[0];
        #200 latch_clock = 1'b1;
        #7.5 latch_clock = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// ==== tb/led_sink_shift_diag_logic_test.sv ====
// Purpose: self-checking bench of the LED sink shift/diag logic
// Assumes: 20 MHz clock, fixed 700-cycle deglitch from the package
// Notes: expected readback is computed here, never taken from the design
`timescale 1ns/1ps
`default_nettype none
module led_sink_shift_diag_logic_test;
    logic clock, sys_rst, clear_n, enable, group_gate_1, group_gate_2;
    logic [led_sink_pkg::PAIRS-1:0] open_cmp, short_cmp;
    logic overtemp_in;
    logic shift_clock, latch_clock, serial_in, serial_out;
    logic [15:0] oe_n;
    logic flag_oe_n;
    logic [15:0] drv_o;
    logic flag_o;
    logic [23:0] r;
    led_sink_pkg::fault_word_t rb;
    int fail_count = 0;
    int num_checks = 0;

    led_sink_shift_diag_logic led_sink_shift_diag_logic_inst (
        .clock(clock), .sys_rst(sys_rst), .clear_n(clear_n),
        .enable(enable), .group_gate_1(group_gate_1),
        .group_gate_2(group_gate_2), .shift_clock(shift_clock),
        .latch_clock(latch_clock), .serial_in(serial_in),
        .serial_out(serial_out), .open_cmp(open_cmp),
        .short_cmp(short_cmp), .overtemp_in(overtemp_in),
        .low_side_out_o(drv_o), .low_side_out_oe_n(oe_n),
        .fault_flag_out_o(flag_o), .fault_flag_out_oe_n(flag_oe_n));

    host_link_model host_link_model_inst (
        .shift_clock(shift_clock), .latch_clock(latch_clock),
        .serial_in(serial_in), .serial_out(serial_out));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rb(input logic [23:0] g, input logic [23:0] e);
        chk(g, e);
    endtask
    task automatic chk_pins(input logic [15:0] g, input logic [15:0] e);
        chk({8'h00, g}, {8'h00, e});
    endtask
    task automatic chk_flag(input logic g, input logic e);
        chk({23'h0, g}, {23'h0, e});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Frame plus settle time for the clock-domain pickup
    task automatic xfer(input logic [23:0] w);
        host_link_model_inst.frame(w, r);
        cycles(8);
        rb = r;
    endtask

    task automatic wait_flag(input logic e);
        int n;
        n = 0;
        while (flag_oe_n !== e && n < 40) begin
            cycles(1);
            n++;
        end
        chk_flag(flag_oe_n, e);
        // A flag that never settles ends the run
        if (flag_oe_n !== e) begin
            wrap_up();
        end
    endtask

    function automatic logic [5:0] crc6(input logic [29:0] x);
        logic [29:0] v;
        v = x;
        for (int i = 29; i >= 6; i--) begin
            if (v[i]) begin
                v[i -: 7] = v[i -: 7] ^ led_sink_pkg::CRC_POLY;
            end
        end
        return v[5:0];
    endfunction

    // Kind 0 open, 1 short, both on pair 2, 2 overtemperature (device-wide)
    task automatic fault_case(input int kind);
        logic [23:0] e;
        xfer(24'h04_0010);
        chk_pins(oe_n, 16'hFFEF);
        if (kind == 0) open_cmp[2] = 1'b1;
        else if (kind == 1) short_cmp[2] = 1'b1;
        else overtemp_in = 1'b1;
        if (kind < 2) begin
            cycles(650);
            chk_flag(flag_oe_n, 1'b1);
            cycles(70);
        end else begin
            cycles(8);
        end
        chk_flag(flag_oe_n, 1'b0);
        chk_pins(oe_n, kind == 2 ? 16'hFFFF : 16'hFFEF);
        group_gate_1 = 1'b1;
        cycles(6);
        group_gate_1 = 1'b0;
        cycles(6);
        chk_flag(flag_oe_n, 1'b0);
        // Read while the condition holds must not clear
        xfer(24'h04_0010);
        open_cmp = '0;
        short_cmp = '0;
        overtemp_in = 1'b0;
        cycles(8);
        chk_flag(flag_oe_n, 1'b0);
        xfer(24'h04_0010);
        e = {(kind == 0) ? 16'h0020 : (kind == 1) ? 16'h0010 : 16'h0000,
             kind == 2, 1'b0, crc6({24'h04_0010, 6'h00})};
        chk_rb(rb, e);
        wait_flag(1'b1);
        $display("test fault kind %0d done", kind);
    endtask

    initial begin
        #1_000_000;
        fail_count++;
        wrap_up();
    end

    initial begin
        clear_n = 1'b0;
        sys_rst = 1'b1;
        enable = 1'b0;
        group_gate_1 = 1'b0;
        group_gate_2 = 1'b0;
        open_cmp = '0;
        short_cmp = '0;
        overtemp_in = 1'b0;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        clear_n = 1'b1;
        cycles(4);
        chk_pins(oe_n, 16'hFFFF);
        chk_flag(flag_oe_n, 1'b1);
        xfer(24'h00_FFFF);
        chk_pins(oe_n, 16'h0000);
        chk_pins(drv_o, 16'h0000);
        chk_flag(flag_o, 1'b0);
        group_gate_1 = 1'b1;
        cycles(6);
        chk_pins(oe_n, 16'h00FF);
        group_gate_1 = 1'b0;
        group_gate_2 = 1'b1;
        cycles(6);
        chk_pins(oe_n, 16'hFF00);
        group_gate_2 = 1'b0;
        $display("test gating done");
        // Pairs 1, 2 and 4 conflict and run as plain outputs
        xfer(24'hD7_0F68);
        chk_rb({18'h0, rb.crc}, {18'h0, crc6({24'h00_FFFF, 6'h00})});
        chk_pins(oe_n, 16'hF097);
        wait_flag(1'b0);
        xfer(24'h00_0000);
        chk_rb({18'h0, rb.crc}, 24'h00_0019);
        chk_rb({18'h0, crc6({24'hD7_0F68, rb.crc})}, 24'h0);
        chk_flag(flag_oe_n, 1'b0);
        xfer(24'h00_0000);
        chk_rb(rb, 24'h00_0040);
        wait_flag(1'b1);
        $display("test conflict and checksum done");
        for (int k = 0; k < 3; k++) begin
            fault_case(k);
        end
        for (int k = 0; k < 2; k++) begin
            xfer(24'h01_0002);
            chk_pins(oe_n, 16'hFFFD);
            wait_flag(1'b0);
            if (k == 0) clear_n = 1'b0;
            else enable = 1'b1;
            cycles(4);
            chk_pins(oe_n, 16'hFFFF);
            chk_flag(flag_oe_n, 1'b1);
            clear_n = 1'b1;
            enable = 1'b0;
            cycles(4);
            chk_pins(oe_n, 16'hFFFF);
            $display("test reset source %0d done", k);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
